// *** logic/repeater_host_regs.vh ***
// timing constants for the repeater enable controller
`ifndef REPEATER_HOST_REGS_VH
`define REPEATER_HOST_REGS_VH

// clock period of CLK_IN in ns
`define RH_CLK_NS 10
// enable high before a start condition, ns
`define RH_EN_SETUP_NS 100
// enable high after a stop condition, ns
`define RH_EN_HOLD_NS 100
// bus free time both sides must show before the enable may move, ns
`define RH_BUS_FREE_NS 4700

// least times round up to whole cycles
`define RH_EN_SETUP_CYC ((`RH_EN_SETUP_NS + `RH_CLK_NS - 1) / `RH_CLK_NS)
`define RH_EN_HOLD_CYC ((`RH_EN_HOLD_NS + `RH_CLK_NS - 1) / `RH_CLK_NS)
`define RH_BUS_FREE_CYC ((`RH_BUS_FREE_NS + `RH_CLK_NS - 1) / `RH_CLK_NS)

// reset values
`define RH_EN_RESET 1'h0
`define RH_LINE_RESET 1'h1

`endif

// *** logic/line_watch.v ***
// two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ns
`default_nettype none
`include "repeater_host_regs.vh"

module line_watch
(
  input  wire clk_in,
  input  wire reset_n_in,
  input  wire line_in,
  output wire level_out,
  output wire fell_out,
  output wire rose_out
);

  reg meta;
  reg sync;
  reg prev;

  // meta is read only by sync; edges compare sync against prev
  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      meta <= `RH_LINE_RESET;
      sync <= `RH_LINE_RESET;
      prev <= `RH_LINE_RESET;
    end
    else
    begin
      meta <= line_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_out = sync;
  assign fell_out  = prev & ~sync;
  assign rose_out  = ~prev & sync;

endmodule // line_watch

`default_nettype wire

// *** logic/repeater_host.v ***
// enable controller and side-B line driver outside the level-shifting repeater
`timescale 1ns/1ns
`default_nettype none
`include "repeater_host_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - this controller moves the enable only while both bus sides are idle.
// - this controller's side B port joins one repeater, never two B ports.
// - this controller pulls side B lines hard to ground, below 0.4 V.
// - side A buses of several repeaters may share one star bus.
module repeater_host
#(
  parameter BUS_FREE_CYC = `RH_BUS_FREE_CYC,
  parameter EN_SETUP_CYC = `RH_EN_SETUP_CYC,
  parameter EN_HOLD_CYC  = `RH_EN_HOLD_CYC
)
(
  input  wire CLK_IN,
  input  wire RESET_N_IN,
  input  wire ENABLE_REQ_IN,
  input  wire B_DATA_LOW_REQ_IN,
  input  wire B_CLOCK_LOW_REQ_IN,
  input  wire A_SIDE_DATA_LINE_IN,
  input  wire A_SIDE_CLOCK_LINE_IN,
  input  wire B_SIDE_DATA_LINE_IN,
  input  wire B_SIDE_CLOCK_LINE_IN,
  output wire EN_OUT,
  output wire B_SIDE_DATA_LINE_OUT,
  output wire B_SIDE_DATA_LINE_OE_OUT,
  output wire B_SIDE_CLOCK_LINE_OUT,
  output wire B_SIDE_CLOCK_LINE_OE_OUT,
  output wire READY_OUT,
  output wire A_BUSY_OUT,
  output wire B_BUSY_OUT,
  output wire IDLE_OUT
);

  localparam [1:0] S_OFF   = 2'h0;
  localparam [1:0] S_SETUP = 2'h1;
  localparam [1:0] S_ON    = 2'h2;

  // index of each watched line: 0 a data, 1 a clock, 2 b data, 3 b clock
  localparam NLINES = 4;

  // the longer of bus free and enable hold must pass before any change
  localparam integer IDLE_RAW =
    (BUS_FREE_CYC > EN_HOLD_CYC) ? BUS_FREE_CYC : EN_HOLD_CYC;
  localparam [12:0] IDLE_CYC  = IDLE_RAW[12:0];
  localparam [12:0] SETUP_CYC = EN_SETUP_CYC[12:0];

  wire [NLINES-1:0] line_raw;
  wire [NLINES-1:0] level;
  wire [NLINES-1:0] fell;
  wire [NLINES-1:0] rose;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         en;
  reg         next_en;
  reg  [12:0] idle_cnt;
  reg  [12:0] setup_cnt;
  reg  [12:0] next_setup_cnt;
  reg         busy_a;
  reg         busy_b;
  reg         drive_data;
  reg         drive_clock;
  reg         low_level;

  wire        idle_ok;
  wire        lines_high;

  ////////////////////////////////////////////////////////////////////////////////
  // line sampling; every pin passes two flops before use

  assign line_raw = {B_SIDE_CLOCK_LINE_IN, B_SIDE_DATA_LINE_IN,
                     A_SIDE_CLOCK_LINE_IN, A_SIDE_DATA_LINE_IN};

  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi = gi + 1)
    begin : g_watch
      line_watch u_watch
      (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .line_in    (line_raw[gi]),
        .level_out  (level[gi]),
        .fell_out   (fell[gi]),
        .rose_out   (rose[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // start and stop tracking on each side; sides are watched separately
  // because they are not joined while the enable is low

  always @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      busy_a <= 1'h0;
      busy_b <= 1'h0;
    end
    else
    begin
      if (fell[0] && level[1])
        busy_a <= 1'h1;
      else if (rose[0] && level[1])
        busy_a <= 1'h0;
      if (fell[2] && level[3])
        busy_b <= 1'h1;
      else if (rose[2] && level[3])
        busy_b <= 1'h0;
    end
  end

  // a lone high line without a stop (e.g. bus reset mid-byte) still counts
  // as busy until a stop is seen; a stuck bus keeps the enable frozen
  assign lines_high = &level;

  always @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      idle_cnt <= 13'h0000;
    else if (!lines_high || busy_a || busy_b)
      idle_cnt <= 13'h0000;
    else if (idle_cnt != IDLE_CYC)
      idle_cnt <= idle_cnt + 13'h0001;
  end

  // both the global bus and the repeater port must be idle
  assign idle_ok = (idle_cnt == IDLE_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // enable state machine

  always @*
  begin
    next_state     = state;
    next_en        = en;
    next_setup_cnt = setup_cnt;
    case (state)
      S_OFF:
      begin
        if (ENABLE_REQ_IN && idle_ok)
        begin
          next_state     = S_SETUP;
          next_en        = 1'h1;
          next_setup_cnt = 13'h0000;
        end
      end
      S_SETUP:
      begin
        if (!ENABLE_REQ_IN && idle_ok)
        begin
          next_state = S_OFF;
          next_en    = 1'h0;
        end
        else if (setup_cnt == SETUP_CYC)
          next_state = S_ON;
        else
          next_setup_cnt = setup_cnt + 13'h0001;
      end
      S_ON:
      begin
        if (!ENABLE_REQ_IN && idle_ok)
        begin
          next_state = S_OFF;
          next_en    = 1'h0;
        end
      end
      default:
      begin
        next_state = S_OFF;
        next_en    = 1'h0;
      end
    endcase
  end

  always @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      state     <= S_OFF;
      en        <= `RH_EN_RESET;
      setup_cnt <= 13'h0000;
    end
    else
    begin
      state     <= next_state;
      en        <= next_en;
      setup_cnt <= next_setup_cnt;
    end
  end

  // enable driven actively both ways; the pull-up only matters if released
  assign EN_OUT = en;

  ////////////////////////////////////////////////////////////////////////////////
  // side B drivers: one direct connection to a single repeater B port

  // a new low is refused during enable setup so no start breaks setup time;
  // a low already held is kept so a stretched clock is not cut short
  always @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      drive_data  <= 1'h0;
      drive_clock <= 1'h0;
      low_level   <= 1'h0;
    end
    else
    begin
      drive_data  <= B_DATA_LOW_REQ_IN &&
                     (state != S_SETUP || drive_data);
      drive_clock <= B_CLOCK_LOW_REQ_IN &&
                     (state != S_SETUP || drive_clock);
      low_level   <= 1'h0;
    end
  end

  // hard ground, never an offset low, so the repeater sees it as external
  assign B_SIDE_DATA_LINE_OUT     = low_level;
  assign B_SIDE_DATA_LINE_OE_OUT  = drive_data;
  assign B_SIDE_CLOCK_LINE_OUT    = low_level;
  assign B_SIDE_CLOCK_LINE_OE_OUT = drive_clock;

  ////////////////////////////////////////////////////////////////////////////////
  // status

  assign READY_OUT  = (state == S_ON);
  // side A may be a shared star bus; its traffic also blocks enable changes
  assign A_BUSY_OUT = busy_a;
  assign B_BUSY_OUT = busy_b;
  assign IDLE_OUT   = idle_ok;

endmodule // repeater_host

`default_nettype wire

// *** bench/repeater_host_sva.sv ***
// port assertions for the repeater enable controller
`timescale 1ns/1ns
`default_nettype none
module repeater_host_chk
(
  input wire logic CLK_IN, RESET_N_IN, ENABLE_REQ_IN, IDLE_OUT, READY_OUT,
  input wire logic B_DATA_LOW_REQ_IN, B_CLOCK_LOW_REQ_IN, EN_OUT,
  input wire logic B_SIDE_DATA_LINE_OUT, B_SIDE_CLOCK_LINE_OUT,
  input wire logic B_SIDE_DATA_LINE_OE_OUT, B_SIDE_CLOCK_LINE_OE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  en_idle_a: assert property ($changed(EN_OUT) |-> $past(IDLE_OUT))
    else $error("enable moved while bus busy");
  en_follow_a: assert property (IDLE_OUT && ENABLE_REQ_IN != EN_OUT
    |=> EN_OUT == $past(ENABLE_REQ_IN)) else $error("enable not taken");
  ready_setup_a: assert property (READY_OUT
    |-> EN_OUT && $past(EN_OUT, 3)) else $error("ready without setup");
  data_oe_a: assert property (B_DATA_LOW_REQ_IN
    && (READY_OUT || !EN_OUT) |=> B_SIDE_DATA_LINE_OE_OUT)
    else $error("data low not driven");
  data_rel_a: assert property (!B_DATA_LOW_REQ_IN
    |=> !B_SIDE_DATA_LINE_OE_OUT) else $error("data low not released");
  clk_oe_a: assert property (B_CLOCK_LOW_REQ_IN == READY_OUT
    && READY_OUT |=> B_SIDE_CLOCK_LINE_OE_OUT)
    else $error("clock low not driven");
  setup_refuse_a: assert property (B_DATA_LOW_REQ_IN && EN_OUT
    && !READY_OUT && !B_SIDE_DATA_LINE_OE_OUT
    |=> !B_SIDE_DATA_LINE_OE_OUT) else $error("low driven in setup");
  line_zero_a: assert property (!B_SIDE_DATA_LINE_OUT
    && !B_SIDE_CLOCK_LINE_OUT) else $error("line level not low");
endmodule // repeater_host_chk
bind repeater_host repeater_host_chk chk_i (.*);
`default_nettype wire

// *** bench/repeater_model.sv ***
// behavioural repeater, channel 0 data and channel 1 clock
`timescale 1ns/1ns
`default_nettype none
module repeater_model
(
  input  wire logic       en_in,
  input  wire logic [1:0] a_in,
  input  wire logic [1:0] b_in,
  output var  logic [1:0] a_pull_out,
  output var  logic [1:0] b_pull_out
);
  logic live = 1'h0;
  // drivers stay off while the supplies ramp
  initial #40 live = 1'h1;
  // no timing of its own, so any bus rate and a star join pass
  always #2
    for (int i = 0; i < 2; i++)
      if (!live || en_in === 1'h0)
      begin
        a_pull_out[i] <= 1'h0;
        b_pull_out[i] <= 1'h0;
      end
      else if (!a_pull_out[i] && !b_pull_out[i])
      begin
        b_pull_out[i] <= !a_in[i];
        a_pull_out[i] <= a_in[i] && !b_in[i];
      end
      else
      begin
        // own b-side low is not read back, so only the far side releases
        if (a_in[i]) b_pull_out[i] <= 1'h0;
        if (b_in[i]) a_pull_out[i] <= 1'h0;
      end
endmodule // repeater_model
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the repeater enable controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK_IN = 0, RESET_N_IN = 0, ENABLE_REQ_IN = 0, lclk = 0, frame = 0;
  logic [1:0] low_req = 0, tb_a = 0, a, b, a_oe, b_oe, h_oe, h_out;
  logic en, rdy, idle, a_busy, b_busy;
  int errors = 0, checks_done = 0, cyc = 0;
  always #5 CLK_IN = ~CLK_IN;
  always
  begin
    #62 lclk = ~lclk;
    #63 lclk = ~lclk;
  end
  // pulled-up lines; lclk reaches the a-side clock only inside a frame
  assign a = ~(a_oe | tb_a | {frame & ~lclk, 1'h0});
  assign b = ~(b_oe | (h_oe & ~h_out));
  repeater_host #(.BUS_FREE_CYC(20), .EN_SETUP_CYC(2), .EN_HOLD_CYC(2)) dut
  (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .ENABLE_REQ_IN(ENABLE_REQ_IN),
    .B_DATA_LOW_REQ_IN(low_req[0]), .B_CLOCK_LOW_REQ_IN(low_req[1]),
    .A_SIDE_DATA_LINE_IN(a[0]), .A_SIDE_CLOCK_LINE_IN(a[1]),
    .B_SIDE_DATA_LINE_IN(b[0]), .B_SIDE_CLOCK_LINE_IN(b[1]),
    .EN_OUT(en), .B_SIDE_DATA_LINE_OUT(h_out[0]),
    .B_SIDE_DATA_LINE_OE_OUT(h_oe[0]), .B_SIDE_CLOCK_LINE_OUT(h_out[1]),
    .B_SIDE_CLOCK_LINE_OE_OUT(h_oe[1]), .READY_OUT(rdy),
    .A_BUSY_OUT(a_busy), .B_BUSY_OUT(b_busy), .IDLE_OUT(idle)
  );
  repeater_model rep
  (
    .en_in(en), .a_in(a), .b_in(b), .a_pull_out(a_oe), .b_pull_out(b_oe)
  );
  task chk(input bit ok, input string m);
    checks_done++;
    if (!ok)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask
  task wait_en(input logic v);
    for (int k = 0; k < 200 && en !== v; k++) @(posedge CLK_IN);
  endtask
  task t_enable;
    chk(en === 1'h0 && h_oe === 2'h0 && idle === 1'h0, "reset state");
    chk(a_busy === 1'h0 && b_busy === 1'h0, "no frame yet");
    ENABLE_REQ_IN <= 1'h1;
    wait_en(1'h1);
    step(4);
    chk(en === 1'h1 && rdy === 1'h1, "enable and ready");
    chk(idle === 1'h1, "still idle after enable");
    for (int i = 0; i < 2; i++)
    begin
      tb_a[i] <= 1'h1;
      step(3);
      chk(b[i] === 1'h0 && b_oe[i] === 1'h1, "a low to b");
      tb_a[i] <= 1'h0;
      step(3);
      low_req[i] <= 1'h1;
      step(4);
      chk(h_oe[i] === 1'h1 && a[i] === 1'h0, "b low to a");
      low_req[i] <= 1'h0;
      step(4);
      chk(h_oe[i] === 1'h0 && a[i] === 1'h1, "b released");
    end
    $display("enable test done");
  endtask
  // drop the enable inside a frame: it must wait for stop and bus free
  task t_frame;
    tb_a[0] <= 1'h1;
    step(5);
    ENABLE_REQ_IN <= 1'h0;
    @(negedge lclk);
    @(posedge CLK_IN);
    frame <= 1'h1;
    for (int k = 0; k < 8; k++)
    begin
      // data moves while the a-side clock is low, on a CLK_IN edge
      @(negedge lclk);
      @(posedge CLK_IN);
      tb_a[0] <= k[0];
      // look well after the clock rises, once the model has followed
      @(posedge lclk);
      step(2);
      chk(b === a && en === 1'h1, "frame passes");
      chk(a_busy === 1'h1 && b_busy === 1'h1 && idle === 1'h0, "busy");
    end
    // end the frame while the clock is high so no false edge appears
    frame <= 1'h0;
    step(5);
    tb_a[0] <= 1'h0;
    wait_en(1'h0);
    chk(en === 1'h0, "enable dropped after stop");
    chk(a_busy === 1'h0 && b_busy === 1'h0 && idle === 1'h1, "idle");
    tb_a[0] <= 1'h1;
    step(3);
    chk(b[0] === 1'h1 && b_oe === 2'h0, "sides isolated");
    tb_a[0] <= 1'h0;
    step(3);
    $display("frame test done");
  endtask
  task t_setup;
    ENABLE_REQ_IN <= 1'h1;
    wait_en(1'h1);
    low_req[0] <= 1'h1;
    step(2);
    chk(h_oe[0] === 1'h0 && rdy === 1'h0, "low held off in setup");
    step(4);
    chk(h_oe[0] === 1'h1 && rdy === 1'h1, "low driven when ready");
    low_req[0] <= 1'h0;
    step(2);
    $display("setup test done");
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge CLK_IN)
    if (++cyc == 3000)
    begin
      errors++;
      print_verdict;
    end
  initial
  begin
    step(6);
    RESET_N_IN <= 1'h1;
    t_enable;
    t_frame;
    t_setup;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
